/* File: hw/sysport_params.svh */
`ifndef SYSPORT_PARAMS_SVH
`define SYSPORT_PARAMS_SVH

// System clock period in nanoseconds (250 MHz).
`define CLK_PERIOD_NS 4

// Register byte offsets on the Avalon-MM slave.
`define OFS_CR1 6'h00
`define OFS_CR2 6'h04
`define OFS_STATUS 6'h08
`define OFS_MASK 6'h0C
`define OFS_LOOP 6'h10
`define OFS_BTX 6'h14
`define OFS_DRX 6'h18

// Field positions of the first control register.
`define CR1_MASTER 0
`define CR1_RATE_LO 1
`define CR1_RATE_HI 2
// Field positions of the second control register.
`define CR2_DEN 0
`define CR2_DSEL 1
// Status and mask bit positions.
`define ST_LOOP 0
`define ST_CTRL 1
`define ST_FRAME 2

// Reset values.
`define CR1_RESET 3'h0
`define CR2_RESET 2'h0

// Master bit clock rates and frame rate in kHz.
`define RATE0_KHZ 512
`define RATE1_KHZ 1536
`define RATE2_KHZ 2048
`define RATE3_KHZ 2560
`define FRAME_KHZ 8
// D-port clock rate and its half period in system cycles.
`define D_PORT_CLOCK_KHZ 16
`define D_PORT_CLOCK_HALF_CYC ((1000000 / `D_PORT_CLOCK_KHZ) / (2 * `CLK_PERIOD_NS))

// B channels occupy the first sixteen bits after frame start.
`define B_SLOT_BITS 16
// Control-port command that reads the status byte and acknowledges.
`define CMD_RD_STATUS 8'hC1

`endif

/* File: hw/sysport_pkg.sv */
package sysport_pkg;
  // One byte of channel or control data.
  typedef logic [7:0] byte_t;
  // Control-port shifter states.
  typedef enum logic [0:0] {CP_IDLE, CP_SHIFT} ctrl_state_t;
endpackage : sysport_pkg

/* File: hw/sync2.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for pin inputs; only stage two is read outside.
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Asynchronous input and synchronised output.
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta; // First stage, read only by the second.

  // Both stages reset to zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : sync2
`default_nettype wire

/* File: hw/ctrl_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sysport_params.svh"
// Serial control port: eight bits per byte, bytes repeat while selected, shifted on sampled clock.
module ctrl_port (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Synchronised pin levels.
  input wire logic en_i,
  input wire logic control_port_clock_i,
  input wire logic din_i,
  // Byte shifted out while a command shifts in.
  input wire sysport_pkg::byte_t status_i,
  // Results.
  output logic dout_o,
  output logic dout_oe_n_o,
  output logic done_o,
  output sysport_pkg::byte_t cmd_o
);
  import sysport_pkg::*;
  ctrl_state_t state, next_state; // Shifter state.
  logic control_port_clock_d, next_control_port_clock_d; // Previous clock level for edge finding.
  logic [2:0] cnt, next_cnt; // Bits taken in this byte.
  byte_t sin, next_sin; // Input shift register.
  byte_t sout, next_sout; // Output shift register.
  logic next_dout, next_oe_n, next_done;
  byte_t next_cmd;

  // Rising edge samples input, falling edge moves output.
  always_comb begin
    next_state = state;
    next_control_port_clock_d = control_port_clock_i;
    next_cnt = cnt;
    next_sin = sin;
    next_sout = sout;
    next_dout = dout_o;
    next_oe_n = 1'b1;
    next_done = 1'b0;
    next_cmd = cmd_o;
    case (state)
      CP_IDLE: begin
        // A fresh select loads the status and drives its first bit.
        if (en_i) begin
          next_state = CP_SHIFT;
          next_cnt = 3'h0;
          next_sout = status_i;
          next_dout = status_i[7];
          next_oe_n = 1'b0;
        end
      end
      CP_SHIFT: begin
        if (!en_i) begin
          // Select released: line floats, partial byte is dropped.
          next_state = CP_IDLE;
        end else begin
          next_oe_n = 1'b0;
          if (control_port_clock_i && !control_port_clock_d) begin
            next_sin = {sin[6:0], din_i};
            next_cnt = cnt + 3'h1;
            if (cnt == 3'h7) begin
              next_done = 1'b1;
              next_cmd = {sin[6:0], din_i};
              next_sout = status_i;
            end
          end else if (!control_port_clock_i && control_port_clock_d) begin
            next_sout = {sout[6:0], 1'b0};
            next_dout = sout[6];
          end
        end
      end
      default: next_state = CP_IDLE;
    endcase
  end

  // Register stage.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= CP_IDLE;
      control_port_clock_d <= 1'b0;
      cnt <= 3'h0;
      sin <= 8'h00;
      sout <= 8'h00;
      dout_o <= 1'b0;
      dout_oe_n_o <= 1'b1;
      done_o <= 1'b0;
      cmd_o <= 8'h00;
    end else begin
      state <= next_state;
      control_port_clock_d <= next_control_port_clock_d;
      cnt <= next_cnt;
      sin <= next_sin;
      sout <= next_sout;
      dout_o <= next_dout;
      dout_oe_n_o <= next_oe_n;
      done_o <= next_done;
      cmd_o <= next_cmd;
    end
  end
endmodule : ctrl_port
`default_nettype wire

/* File: hw/system_port.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sysport_params.svh"
module system_port #(
  parameter int D_PORT_CLOCK_HALF = `D_PORT_CLOCK_HALF_CYC
) (
  // Clock and reset.
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Avalon-MM slave.
  input wire logic [5:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [3:0] AVS_BYTEENABLE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  output logic IRQ_O,
  // Line-side data and loop status, on the system clock.
  input wire logic [3:0] LOOP_STATUS_I,
  input wire sysport_pkg::byte_t B1_LINE_RX_I,
  input wire sysport_pkg::byte_t B2_LINE_RX_I,
  input wire sysport_pkg::byte_t D_LINE_RX_I,
  // Control port pins.
  input wire logic INTERFACE_SELECT_I,
  input wire logic CONTROL_PORT_CLOCK_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic CTRL_DATA_IN_I,
  output logic CTRL_DATA_OUT_O,
  output logic CTRL_DATA_OUT_OE_N_O,
  output logic INTERRUPT_N_O,
  output logic INTERRUPT_N_OE_N_O,
  // B-channel pins.
  input wire logic BIT_CLOCK_I,
  output logic BIT_CLOCK_O,
  output logic BIT_CLOCK_OE_N_O,
  input wire logic TRANSMIT_FRAME_SYNC_I,
  output logic TRANSMIT_FRAME_SYNC_O,
  output logic TRANSMIT_FRAME_SYNC_OE_N_O,
  input wire logic B_DATA_INPUT_I,
  output logic B_DATA_OUTPUT_O,
  output logic B_DATA_OUTPUT_OE_N_O,
  // D-port pins.
  input wire logic D_CHANNEL_TX_INPUT_I,
  output logic D_CHANNEL_RX_OUTPUT_O,
  output logic D_CHANNEL_RX_OUTPUT_OE_N_O,
  output logic D_PORT_CLOCK_O,
  output logic D_PORT_CLOCK_OE_N_O
);
  import sysport_pkg::*;

  // Half period of the master bit clock in system cycles.
  function automatic logic [7:0] bclk_half(input logic [1:0] sel);
    int khz;
    khz = (sel == 2'h0) ? `RATE0_KHZ : (sel == 2'h1) ? `RATE1_KHZ :
          (sel == 2'h2) ? `RATE2_KHZ : `RATE3_KHZ;
    return 8'((1000000 / khz) / (2 * `CLK_PERIOD_NS));
  endfunction : bclk_half

  // Bit periods per 8 kHz frame at the selected master rate.
  function automatic logic [8:0] frame_bits(input logic [1:0] sel);
    int khz;
    khz = (sel == 2'h0) ? `RATE0_KHZ : (sel == 2'h1) ? `RATE1_KHZ :
          (sel == 2'h2) ? `RATE2_KHZ : `RATE3_KHZ;
    return 9'(khz / `FRAME_KHZ);
  endfunction : frame_bits

  // Every pin input passes two flops; the control clock may be unrelated.
  logic [7:0] pin_s; // Synchronised pin levels.
  sync2 #(.W(8)) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .d_i({INTERFACE_SELECT_I, CONTROL_PORT_CLOCK_I, CHIP_SELECT_N_I,
          CTRL_DATA_IN_I, BIT_CLOCK_I, TRANSMIT_FRAME_SYNC_I,
          B_DATA_INPUT_I, D_CHANNEL_TX_INPUT_I}),
    .q_o(pin_s)
  );
  logic isel_s, control_port_clock_s, cs_n_s, cdin_s, bclk_s, fs_s, bx_s, dx_s;
  assign {isel_s, control_port_clock_s, cs_n_s, cdin_s, bclk_s, fs_s, bx_s, dx_s} = pin_s;

  // Software-visible registers.
  logic [2:0] cr1, next_cr1; // Master role and rate select.
  logic [1:0] cr2, next_cr2; // D-port enable and clock select.
  logic [2:0] status, next_status; // Sticky events.
  logic [2:0] mask, next_mask; // Interrupt enables.
  logic [15:0] b_tx, next_b_tx; // Last captured B1 and B2 bytes.
  byte_t d_rx, next_d_rx; // Last captured D byte.
  logic wait_q, next_wait; // Registered waitrequest.
  logic [31:0] next_rdata;
  logic next_irq;
  wire cr1_master = cr1[`CR1_MASTER];
  wire [1:0] cr1_rate = cr1[`CR1_RATE_HI:`CR1_RATE_LO];
  wire d_en = cr2[`CR2_DEN];
  wire d_sel = cr2[`CR2_DSEL];

  // Control port and interrupt latch.
  logic cp_done; // One byte completed under select.
  byte_t cp_cmd; // That byte.
  logic cp_dout, cp_oe_n;
  logic intr, next_intr; // Interrupt latch.
  logic [3:0] loop_d; // Previous loop status.
  wire ctrl_en = isel_s && !cs_n_s;
  wire loop_chg = (LOOP_STATUS_I != loop_d);
  wire rd_status = cp_done && (cp_cmd == `CMD_RD_STATUS);

  ctrl_port u_ctrl (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .en_i(ctrl_en),
    .control_port_clock_i(control_port_clock_s),
    .din_i(cdin_s),
    .status_i({intr, status, LOOP_STATUS_I}),
    .dout_o(cp_dout),
    .dout_oe_n_o(cp_oe_n),
    .done_o(cp_done),
    .cmd_o(cp_cmd)
  );

  // Bit clock, frame timing and B/D channel state.
  logic [7:0] bdiv, next_bdiv; // Master bit clock divider.
  logic bgen, next_bgen; // Generated bit clock level.
  logic bclk_d, next_bclk_d; // Previous bit clock level.
  logic fs_d, next_fs_d; // Previous frame sync level.
  logic fs_pend, next_fs_pend; // Frame sync seen, waiting for bit edge.
  logic [8:0] bit_cnt, next_bit_cnt; // Bit position in frame.
  logic [15:0] bsh, next_bsh; // B input shift register.
  logic [13:0] ddiv, next_ddiv; // D-port clock divider.
  logic dgen, next_dgen; // Generated D-port clock level.
  logic d_port_clock_d, next_d_port_clock_d; // Previous selected D clock level.
  byte_t dsh, next_dsh; // D input shift register.
  logic [2:0] dbit, next_dbit; // D bit position.
  logic next_br, next_br_oe_n, next_dr, next_fs_o;
  wire bclk_cur = cr1_master ? bgen : bclk_s;
  wire b_rise = bclk_cur && !bclk_d;
  wire b_fall = !bclk_cur && bclk_d;
  wire fs_rise = fs_s && !fs_d;
  wire d_port_clock_cur = d_sel ? bclk_cur : dgen;
  wire d_rise = d_port_clock_cur && !d_port_clock_d;
  wire d_fall = !d_port_clock_cur && d_port_clock_d;
  wire [15:0] b_line = {B1_LINE_RX_I, B2_LINE_RX_I};

  // Bus, registers and interrupt; every event flag lets the set win.
  always_comb begin
    next_cr1 = cr1;
    next_cr2 = cr2;
    next_mask = mask;
    next_status = status;
    next_wait = !((AVS_READ_I || AVS_WRITE_I) && wait_q);
    next_rdata = AVS_READDATA_O;
    if (AVS_READ_I && wait_q) begin
      case (AVS_ADDRESS_I)
        `OFS_CR1: next_rdata = {29'h0, cr1};
        `OFS_CR2: next_rdata = {30'h0, cr2};
        `OFS_STATUS: next_rdata = {29'h0, status};
        `OFS_MASK: next_rdata = {29'h0, mask};
        `OFS_LOOP: next_rdata = {18'h0, isel_s, intr, cp_cmd, LOOP_STATUS_I};
        `OFS_BTX: next_rdata = {16'h0, b_tx};
        `OFS_DRX: next_rdata = {24'h0, d_rx};
        default: next_rdata = 32'h0; // Unmapped reads as zero.
      endcase
    end
    if (AVS_WRITE_I && !wait_q && AVS_BYTEENABLE_I[0]) begin
      case (AVS_ADDRESS_I)
        `OFS_CR1: next_cr1 = AVS_WRITEDATA_I[2:0];
        `OFS_CR2: next_cr2 = AVS_WRITEDATA_I[1:0];
        `OFS_STATUS: next_status = status & ~AVS_WRITEDATA_I[2:0];
        `OFS_MASK: next_mask = AVS_WRITEDATA_I[2:0];
        default: next_status = next_status; // Writes elsewhere are dropped.
      endcase
    end
    if (loop_chg) next_status[`ST_LOOP] = 1'b1;
    if (cp_done) next_status[`ST_CTRL] = 1'b1;
    if (b_rise && next_bit_cnt == 9'h0) next_status[`ST_FRAME] = 1'b1;
    next_irq = |(next_status & next_mask);
    // Pin latch: a change in the same cycle as the read keeps it set.
    next_intr = intr;
    if (rd_status) next_intr = 1'b0;
    if (loop_chg) next_intr = 1'b1;
  end

  // Frame, B channel and D port next values.
  always_comb begin
    next_bclk_d = bclk_cur;
    next_fs_d = fs_s;
    next_d_port_clock_d = d_port_clock_cur;
    next_bdiv = bdiv;
    next_bgen = bgen;
    next_ddiv = ddiv;
    next_dgen = dgen;
    next_fs_pend = fs_pend;
    next_bit_cnt = bit_cnt;
    next_bsh = bsh;
    next_b_tx = b_tx;
    next_br = B_DATA_OUTPUT_O;
    next_br_oe_n = B_DATA_OUTPUT_OE_N_O;
    next_fs_o = TRANSMIT_FRAME_SYNC_O;
    next_dsh = dsh;
    next_dbit = dbit;
    next_d_rx = d_rx;
    next_dr = D_CHANNEL_RX_OUTPUT_O;
    // The divider toggles the master bit clock at the chosen rate.
    if (!cr1_master) begin
      next_bdiv = 8'h0;
      next_bgen = 1'b0;
    end else if (bdiv >= bclk_half(cr1_rate) - 8'h1) begin
      next_bdiv = 8'h0;
      next_bgen = !bgen;
    end else begin
      next_bdiv = bdiv + 8'h1;
    end
    if (fs_rise && !cr1_master) next_fs_pend = 1'b1;
    if (b_rise) begin
      if (cr1_master) begin
        next_bit_cnt = (bit_cnt >= frame_bits(cr1_rate) - 9'h1) ? 9'h0 :
                       bit_cnt + 9'h1;
      end else if (fs_pend || fs_rise) begin
        next_bit_cnt = 9'h0;
        next_fs_pend = 1'b0;
      end else if (bit_cnt != 9'h1FF) begin
        next_bit_cnt = bit_cnt + 9'h1; // Parks until the next sync.
      end
      next_fs_o = cr1_master && (next_bit_cnt == 9'h0);
      // Drive only inside the B1 and B2 slots, MSB first.
      next_br_oe_n = !(next_bit_cnt < `B_SLOT_BITS);
      next_br = b_line[4'hF - next_bit_cnt[3:0]];
    end
    if (b_fall && bit_cnt < `B_SLOT_BITS) begin
      next_bsh = {bsh[14:0], bx_s};
      if (bit_cnt == `B_SLOT_BITS - 1) next_b_tx = {bsh[14:0], bx_s};
    end
    // The D-port clock runs only while the port is enabled.
    if (!d_en) begin
      next_ddiv = 14'h0;
      next_dgen = 1'b0;
      next_dbit = 3'h0;
    end else begin
      if (ddiv >= 14'(D_PORT_CLOCK_HALF - 1)) begin
        next_ddiv = 14'h0;
        next_dgen = !dgen;
      end else begin
        next_ddiv = ddiv + 14'h1;
      end
      if (d_rise) next_dr = D_LINE_RX_I[3'h7 - dbit];
      if (d_fall) begin
        next_dsh = {dsh[6:0], dx_s};
        next_dbit = dbit + 3'h1;
        if (dbit == 3'h7) next_d_rx = {dsh[6:0], dx_s};
      end
    end
  end

  // Register stage for all of the above.
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cr1 <= `CR1_RESET;
      cr2 <= `CR2_RESET;
      status <= 3'h0;
      mask <= 3'h0;
      b_tx <= 16'h0000;
      d_rx <= 8'h00;
      wait_q <= 1'b1;
      AVS_READDATA_O <= 32'h0;
      AVS_WAITREQUEST_O <= 1'b1;
      IRQ_O <= 1'b0;
      intr <= 1'b0;
      loop_d <= 4'h0;
      bdiv <= 8'h0;
      bgen <= 1'b0;
      bclk_d <= 1'b0;
      fs_d <= 1'b0;
      fs_pend <= 1'b0;
      bit_cnt <= 9'h1FF;
      bsh <= 16'h0000;
      ddiv <= 14'h0;
      dgen <= 1'b0;
      d_port_clock_d <= 1'b0;
      dsh <= 8'h00;
      dbit <= 3'h0;
      CTRL_DATA_OUT_O <= 1'b0;
      CTRL_DATA_OUT_OE_N_O <= 1'b1;
      INTERRUPT_N_O <= 1'b0;
      INTERRUPT_N_OE_N_O <= 1'b1;
      BIT_CLOCK_O <= 1'b0;
      BIT_CLOCK_OE_N_O <= 1'b1;
      TRANSMIT_FRAME_SYNC_O <= 1'b0;
      TRANSMIT_FRAME_SYNC_OE_N_O <= 1'b1;
      B_DATA_OUTPUT_O <= 1'b0;
      B_DATA_OUTPUT_OE_N_O <= 1'b1;
      D_CHANNEL_RX_OUTPUT_O <= 1'b0;
      D_CHANNEL_RX_OUTPUT_OE_N_O <= 1'b1;
      D_PORT_CLOCK_O <= 1'b0;
      D_PORT_CLOCK_OE_N_O <= 1'b1;
    end else begin
      cr1 <= next_cr1;
      cr2 <= next_cr2;
      status <= next_status;
      mask <= next_mask;
      b_tx <= next_b_tx;
      d_rx <= next_d_rx;
      wait_q <= next_wait;
      AVS_READDATA_O <= next_rdata;
      AVS_WAITREQUEST_O <= next_wait;
      IRQ_O <= next_irq;
      intr <= next_intr;
      loop_d <= LOOP_STATUS_I;
      bdiv <= next_bdiv;
      bgen <= next_bgen;
      bclk_d <= next_bclk_d;
      fs_d <= next_fs_d;
      fs_pend <= next_fs_pend;
      bit_cnt <= next_bit_cnt;
      bsh <= next_bsh;
      ddiv <= next_ddiv;
      dgen <= next_dgen;
      d_port_clock_d <= next_d_port_clock_d;
      dsh <= next_dsh;
      dbit <= next_dbit;
      CTRL_DATA_OUT_O <= cp_dout;
      CTRL_DATA_OUT_OE_N_O <= cp_oe_n || !ctrl_en;
      INTERRUPT_N_O <= 1'b0; // Open drain only ever pulls low.
      INTERRUPT_N_OE_N_O <= !next_intr;
      BIT_CLOCK_O <= next_bgen;
      BIT_CLOCK_OE_N_O <= !cr1_master;
      TRANSMIT_FRAME_SYNC_O <= next_fs_o;
      TRANSMIT_FRAME_SYNC_OE_N_O <= !cr1_master;
      B_DATA_OUTPUT_O <= next_br;
      B_DATA_OUTPUT_OE_N_O <= next_br_oe_n;
      D_CHANNEL_RX_OUTPUT_O <= next_dr;
      D_CHANNEL_RX_OUTPUT_OE_N_O <= !d_en;
      D_PORT_CLOCK_O <= next_dgen;
      D_PORT_CLOCK_OE_N_O <= !d_en;
    end
  end

  // Checks on the design's own outputs and internal state.
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  a_ctrl_gated: assert property (!isel_s |=> !cp_done)
    else $error("control byte completed with port deselected");
  a_cs_float: assert property (cs_n_s |=> ##1 CTRL_DATA_OUT_OE_N_O)
    else $error("control output driven while chip select high");
  a_int_set: assert property (loop_chg |=> !INTERRUPT_N_OE_N_O && intr)
    else $error("loop change did not pull interrupt low");
  a_int_clear: assert property (rd_status && !loop_chg |=> INTERRUPT_N_OE_N_O)
    else $error("status read did not release interrupt");
  a_bclk_dir: assert property (BIT_CLOCK_OE_N_O == !$past(cr1_master))
    else $error("bit clock direction does not follow role");
  a_slave_fs: assert property (!cr1_master && fs_rise ##1 !cr1_master
    |-> ##[1:1000] (bit_cnt == 9'h0))
    else $error("frame sync did not restart the frame");
  a_br_slot: assert property (!B_DATA_OUTPUT_OE_N_O |-> bit_cnt < `B_SLOT_BITS)
    else $error("B output driven outside its slots");
  a_dport_off: assert property (!d_en && !$past(d_en)
    |-> D_PORT_CLOCK_OE_N_O && D_CHANNEL_RX_OUTPUT_OE_N_O && !dgen)
    else $error("disabled D port still driving");
  a_irq_level: assert property (IRQ_O == |(status & mask))
    else $error("interrupt output disagrees with status and mask");
  c_master_frame: cover property (cr1_master && b_rise && next_bit_cnt == 9'h0);
  c_status_read: cover property (rd_status ##1 INTERRUPT_N_OE_N_O);
  c_d_byte: cover property (d_en && d_fall && dbit == 3'h7);
endmodule : system_port
`default_nettype wire

/* File: dv/far_side.sv */
`timescale 1ns/1ns
`default_nettype none
// Far-side model: a controller on the serial control port and a TDM backplane master.
module far_side (
  // Control port pins toward the device.
  output logic control_port_clock_o,
  output logic cs_n_o,
  output logic din_o,
  // Backplane pins toward the device.
  output logic bclk_o,
  output logic fs_o,
  output logic bx_o,
  // Received B data and its enable.
  input wire logic br_i,
  input wire logic br_oe_n_i
);
  import sysport_pkg::*;
  // Both clocks stand still between transfers.
  initial begin
    control_port_clock_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
    bclk_o = 1'b0;
    fs_o = 1'b0;
    bx_o = 1'b0;
  end
  // One byte MSB first; the odd start offset keeps the clock unrelated in phase.
  task automatic send(input byte_t tx, input logic sel);
    #1;
    cs_n_o = !sel;
    #12;
    for (int i = 7; i >= 0; i--) begin
      din_o = tx[i];
      #12;
      control_port_clock_o = 1'b1;
      #24;
      control_port_clock_o = 1'b0;
      #12;
    end
    cs_n_o = 1'b1;
    din_o = !din_o;
  endtask : send
  // One frame at 2 MHz: sync rise, then 24 bits; Br and its enable are captured late.
  task automatic frame(input logic [15:0] tx, output logic [15:0] rx, output logic [23:0] oe_n);
    #1;
    fs_o = 1'b1;
    #100;
    for (int k = 0; k < 24; k++) begin
      bclk_o = 1'b1;
      bx_o = (k < 16) ? tx[15-k] : !bx_o;
      #240;
      fs_o = 1'b0;
      oe_n[k] = br_oe_n_i;
      if (k < 16) rx[15-k] = br_i;
      #10;
      bclk_o = 1'b0;
      #250;
    end
    bx_o = !bx_o;
  endtask : frame
endmodule : far_side
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sysport_params.svh"
module tb;
  import sysport_pkg::*;
  // Clock, reset and bookkeeping.
  logic clk = 1'b0;
  logic rst = 1'b1;
  int seed = 50614;
  int bad_count = 0;
  int n_checks = 0;
  int m_st = 0;
  int m_mask = 0;
  int p;
  int csh = 0;
  int rate_khz[4] = '{`RATE0_KHZ, `RATE1_KHZ, `RATE2_KHZ, `RATE3_KHZ};
  // Bus master and line-side stimulus.
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q;
  logic [3:0] loop = 4'h0;
  byte_t b1 = 8'h00;
  byte_t b2 = 8'h00;
  byte_t c;
  byte_t cbyte; // Bits the controller took from the control output.
  logic isel = 1'b1;
  logic dx = 1'b0;
  logic [15:0] tx;
  logic [15:0] rx;
  logic [23:0] oen;
  // Device outputs.
  wire [31:0] rdat;
  wire waitreq, irq, control_port_clock, cs_n, cdin, bclk, fs, bx, cdout, cdout_oe_n, int_oe_n;
  wire bclk_o, bclk_oe_n, br, br_oe_n, dr, dr_oe_n, d_port_clock, d_port_clock_oe_n;
  // The system clock; the D divider is shortened to eight cycles per half.
  initial begin
    forever #2 clk = !clk;
  end
  system_port #(.D_PORT_CLOCK_HALF(8)) i_dut (.CLK_SYS_I(clk), .RST_I(rst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_BYTEENABLE_I(4'hF), .AVS_WRITEDATA_I(wdat),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq), .IRQ_O(irq), .LOOP_STATUS_I(loop),
    .B1_LINE_RX_I(b1), .B2_LINE_RX_I(b2), .D_LINE_RX_I(8'hFF), .INTERFACE_SELECT_I(isel),
    .CONTROL_PORT_CLOCK_I(control_port_clock), .CHIP_SELECT_N_I(cs_n), .CTRL_DATA_IN_I(cdin),
    .CTRL_DATA_OUT_O(cdout), .CTRL_DATA_OUT_OE_N_O(cdout_oe_n), .INTERRUPT_N_O(),
    .INTERRUPT_N_OE_N_O(int_oe_n), .BIT_CLOCK_I(bclk), .BIT_CLOCK_O(bclk_o),
    .BIT_CLOCK_OE_N_O(bclk_oe_n), .TRANSMIT_FRAME_SYNC_I(fs), .TRANSMIT_FRAME_SYNC_O(),
    .TRANSMIT_FRAME_SYNC_OE_N_O(), .B_DATA_INPUT_I(bx), .B_DATA_OUTPUT_O(br),
    .B_DATA_OUTPUT_OE_N_O(br_oe_n), .D_CHANNEL_TX_INPUT_I(dx), .D_CHANNEL_RX_OUTPUT_O(dr),
    .D_CHANNEL_RX_OUTPUT_OE_N_O(dr_oe_n), .D_PORT_CLOCK_O(d_port_clock), .D_PORT_CLOCK_OE_N_O(d_port_clock_oe_n));
  far_side i_far (.control_port_clock_o(control_port_clock), .cs_n_o(cs_n), .din_o(cdin), .bclk_o(bclk), .fs_o(fs),
    .bx_o(bx), .br_i(br), .br_oe_n_i(br_oe_n));
  // One comparison; an unknown never counts as a match.
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : chk
  // One Avalon transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    r = rdat;
    if (n >= 100) chk(1'b0, "bus timeout");
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  // A control byte, then time for the synchronisers to settle.
  task automatic cp(input byte_t b, input logic s);
    i_far.send(b, s);
    repeat (8) @(posedge clk);
  endtask : cp
  // Cycles between two rising edges of the bit clock (0) or the D clock (1).
  task automatic period(input int which, output int n);
    int k;
    n = 0;
    for (k = 0; k < 4000 && (which ? d_port_clock : bclk_o) !== 1'b0; k++) @(posedge clk);
    for (k = 0; k < 4000 && (which ? d_port_clock : bclk_o) !== 1'b1; k++) @(posedge clk);
    // Count the high phase and then the low phase after a rising edge.
    for (k = 0; k < 4000 && (which ? d_port_clock : bclk_o) !== 1'b0; k++) begin
      @(posedge clk);
      n++;
    end
    for (k = 0; k < 4000 && (which ? d_port_clock : bclk_o) !== 1'b1; k++) begin
      @(posedge clk);
      n++;
    end
  endtask : period
  // The control output must float a few cycles after chip select rises.
  always @(posedge clk) begin
    csh <= (cs_n === 1'b1) ? csh + 1 : 0;
    if (!rst && csh > 6 && cdout_oe_n !== 1'b1) chk(1'b0, "control output driven");
  end
  // The controller takes each output bit on its clock's rise while selected.
  always @(posedge control_port_clock) begin
    if (cs_n === 1'b0) cbyte <= {cbyte[6:0], cdout};
  end
  // Verdict and end of run.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : complete_run
  // Watchdog: the tests need well under 60 microseconds.
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(waitreq === 1'b1 && irq === 1'b0 && int_oe_n === 1'b1 && br_oe_n === 1'b1, "reset");
    chk(dr_oe_n === 1'b1 && d_port_clock_oe_n === 1'b1 && bclk_oe_n === 1'b1, "reset pins");
    bus(1'b0, `OFS_CR1, 32'h0, q);
    chk(q === 32'h0, "first control register reset");
    bus(1'b0, 6'h1C, 32'h0, q);
    chk(q === 32'h0, "unmapped read");
    $display("Test reset ended");
    c = 8'($random(seed)) | 8'h02;
    if (c === `CMD_RD_STATUS) c = 8'h5A;
    isel <= 1'b0;
    cp(c, 1'b1);
    isel <= 1'b1;
    cp(c, 1'b0);
    bus(1'b0, `OFS_LOOP, 32'h0, q);
    chk(q[11:4] === 8'h00, "byte taken while disabled or deselected");
    cp(c, 1'b1);
    bus(1'b0, `OFS_LOOP, 32'h0, q);
    chk(q[11:4] === c, "control byte");
    $display("Test control port ended");
    m_mask = 1;
    bus(1'b1, `OFS_MASK, 32'h1, q);
    bus(1'b1, `OFS_STATUS, 32'h7, q);
    loop <= loop ^ 4'($random(seed) | 1);
    m_st = 1;
    repeat (6) @(posedge clk);
    chk(int_oe_n === 1'b0 && irq === ((m_st & m_mask) != 0), "interrupt raise");
    bus(1'b1, `OFS_STATUS, 32'h1, q);
    m_st = 0;
    chk(irq === ((m_st & m_mask) != 0) && int_oe_n === 1'b0, "latch holds");
    cp(`CMD_RD_STATUS, 1'b1);
    chk(int_oe_n === 1'b1, "status read releases");
    chk(cbyte === {1'b1, 3'(m_st), loop}, "status byte shifted out");
    m_mask = 0;
    bus(1'b1, `OFS_MASK, 32'h0, q);
    loop <= loop ^ 4'h8;
    repeat (6) @(posedge clk);
    chk(irq === 1'b0 && int_oe_n === 1'b0, "masked event");
    $display("Test interrupt ended");
    b1 <= 8'($random(seed));
    b2 <= 8'($random(seed));
    tx = 16'($random(seed));
    @(posedge clk);
    i_far.frame(tx, rx, oen);
    @(posedge clk);
    chk(rx === {b1, b2} && oen === 24'hFF0000, "slot data and enable");
    bus(1'b0, `OFS_BTX, 32'h0, q);
    chk(q[15:0] === tx, "captured B data");
    $display("Test slave frame ended");
    for (int r = 0; r < 4; r++) begin
      bus(1'b1, `OFS_CR1, 32'(r * 2 + 1), q);
      period(0, p);
      chk(p == ((1000000 / rate_khz[r]) / (2 * `CLK_PERIOD_NS)) * 2, "bit clock rate");
      chk(bclk_oe_n === 1'b0, "bit clock driven");
    end
    bus(1'b1, `OFS_CR1, 32'h0, q);
    $display("Test master rates ended");
    dx <= 1'b1;
    bus(1'b1, `OFS_CR2, 32'h1, q);
    period(1, p);
    chk(p == 16 && d_port_clock_oe_n === 1'b0, "D clock");
    repeat (300) @(posedge clk);
    chk(dr === 1'b1 && dr_oe_n === 1'b0, "D output");
    bus(1'b0, `OFS_DRX, 32'h0, q);
    chk(q[7:0] === 8'hFF, "D input byte");
    bus(1'b1, `OFS_CR2, 32'h0, q);
    repeat (8) @(posedge clk);
    chk(d_port_clock_oe_n === 1'b1 && dr_oe_n === 1'b1, "D port off");
    $display("Test D port ended");
    complete_run();
  end
endmodule : tb
`default_nettype wire
